/* rtl/act_pkg.sv */
// ----------------------------------------------------------------------------
// Register map, field layout and encodings of the computation register bank.
// ----------------------------------------------------------------------------
package act_pkg;

  // Bus geometry: each register takes one aligned 32-bit word.
  localparam int unsigned ADR_W  = 10;             // Byte address width.
  localparam int unsigned DAT_W  = 32;             // Bus data width.
  localparam int unsigned SEL_W  = 4;              // Byte select width.

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_LOWER_THRESHOLD = 8'h8c;  // Signed lower limit.
  localparam logic [7:0] IDX_UPPER_THRESHOLD = 8'h8e;  // Signed upper limit.
  localparam logic [7:0] IDX_COMPUTED_ERROR  = 8'h90;  // Read-only error.
  localparam logic [7:0] IDX_SETPOINT        = 8'h92;  // Signed setpoint.
  localparam logic [7:0] IDX_FILTER_OUTPUT   = 8'h94;  // Read-only filter.
  localparam logic [7:0] IDX_ACCUMULATOR     = 8'h96;  // Sign-extended sum.
  localparam logic [7:0] IDX_CONTROL         = 8'ha0;  // Mode selections.
  localparam logic [7:0] IDX_FLAGS           = 8'ha1;  // Comparison flags.
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'ha2;  // Sticky events, W1C.
  localparam logic [7:0] IDX_IRQ_MASK        = 8'ha3;  // Interrupt enables.

  // Control register field positions (each field is three bits wide).
  localparam int unsigned CTL_TMD_LSB   = 0;       // Threshold mode.
  localparam int unsigned CTL_ERROR_SELECT_A_LSB  = 4;       // Error calculation.
  localparam int unsigned CTL_SHIFT_LSB = 8;       // Filter shift.
  localparam int unsigned CTL_MODE_LSB  = 12;      // Computation mode.

  // Interrupt status bit positions.
  localparam int unsigned IRQ_THR_BIT   = 0;       // Threshold condition met.
  localparam int unsigned IRQ_DONE_BIT  = 1;       // Computation finished.
  localparam int unsigned IRQ_W         = 2;       // Number of event bits.

  // Reset values.
  localparam logic [15:0] RST_WORD16 = 16'h0000;   // Thresholds, setpoint.
  localparam logic [17:0] RST_ACC    = 18'h00000;  // Accumulator.
  localparam logic [15:0] RST_CTRL   = 16'h0000;   // Control register.
  localparam logic [1:0]  RST_IRQ    = 2'h0;       // Status and mask.

  // Computation modes.
  localparam logic [2:0] MODE_BASIC  = 3'h0;       // No accumulation.
  localparam logic [2:0] MODE_ACCUM  = 3'h1;       // Accumulate.
  localparam logic [2:0] MODE_AVG    = 3'h2;       // Average.
  localparam logic [2:0] MODE_BURST  = 3'h3;       // Burst average.
  localparam logic [2:0] MODE_LPF    = 3'h4;       // Low-pass filter.

  // Error calculation selections.
  localparam logic [2:0] ERROR_SELECT_A_DERIV   = 3'h0;      // Result minus previous.
  localparam logic [2:0] ERROR_SELECT_A_CVD     = 3'h1;      // Differential result.
  localparam logic [2:0] ERROR_SELECT_A_RES_SP  = 3'h2;      // Result minus setpoint.
  localparam logic [2:0] ERROR_SELECT_A_RES_FLT = 3'h3;      // Result minus filter.
  localparam logic [2:0] ERROR_SELECT_A_FLT_DRV = 3'h4;      // Filter derivative.
  localparam logic [2:0] ERROR_SELECT_A_FLT_SP  = 3'h5;      // Filter minus setpoint.

  // Threshold modes.
  localparam logic [2:0] TMD_NEVER   = 3'h0;       // Never interrupt.
  localparam logic [2:0] TMD_LT_LOW  = 3'h1;       // Error below lower.
  localparam logic [2:0] TMD_GE_LOW  = 3'h2;       // Error at or above lower.
  localparam logic [2:0] TMD_INSIDE  = 3'h3;       // Between, inclusive.
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;       // Outside the window.
  localparam logic [2:0] TMD_LE_UP   = 3'h5;       // Error at or below upper.
  localparam logic [2:0] TMD_GT_UP   = 3'h6;       // Error above upper.
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;       // Always interrupt.

endpackage

/* rtl/act_regs.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Computation register bank with threshold comparison.
// ----------------------------------------------------------------------------

module act_regs
  import act_pkg::*;
(
  input  wire logic                     CLK,            // System clock, 100 MHz.
  input  wire logic                     RESET_N,        // Asynchronous reset, low.
  input  wire logic [act_pkg::ADR_W-1:0] WB_ADR_I,      // Byte address.
  input  wire logic [act_pkg::DAT_W-1:0] WB_DAT_I,      // Write data.
  output logic      [act_pkg::DAT_W-1:0] WB_DAT_O,      // Read data.
  input  wire logic [act_pkg::SEL_W-1:0] WB_SEL_I,      // Byte selects.
  input  wire logic                     WB_WE_I,        // Write enable.
  input  wire logic                     WB_CYC_I,       // Bus cycle.
  input  wire logic                     WB_STB_I,       // Strobe.
  output logic                          WB_ACK_O,       // Acknowledge.
  input  wire logic                     COMPUTE_DONE,   // New result pulse.
  input  wire logic [15:0]              CONV_RESULT,    // Signed result.
  output logic                          ABOVE_UPPER,    // Error above upper.
  output logic                          BELOW_LOWER,    // Error below lower.
  output logic                          IRQ             // Interrupt, level.
);
  import act_pkg::*;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Merges a byte-wide write into a 16-bit register, one lane per byte.
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    logic [15:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wdat[15:8];
    end
    return v;
  endfunction

  // Sign-extends a 16-bit value to the 18-bit arithmetic width.
  function automatic logic [17:0] sext18(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [15:0]        lower_threshold_reg;     // Lower limit value.
  logic [15:0]        upper_threshold_reg;     // Upper limit value.
  logic [15:0]        threshold_setpoint_reg;  // Setpoint value.
  logic [15:0]        computed_error_reg;      // Error value.
  logic [15:0]        filter_output_reg;       // Filtered value.
  logic [17:0]        accumulator_reg;         // Accumulated value.
  logic [15:0]        control_reg;             // Mode selections.
  logic               above_upper_flag_reg;    // Error above upper limit.
  logic               below_lower_flag_reg;    // Error below lower limit.
  logic [IRQ_W-1:0]   irq_status_reg;          // Sticky event bits.
  logic [IRQ_W-1:0]   irq_mask_reg;            // Event enables.
  logic [15:0]        result_reg;              // Latest conversion.
  logic [15:0]        prev_result_reg;         // Conversion before it.
  logic [15:0]        prev_filter_reg;         // Filter before update.
  logic               error_select_a_pulse_reg;          // Error stage strobe.
  logic               cmp_pulse_reg;           // Comparison stage strobe.
  logic               ack_reg;                 // Bus acknowledge.
  logic [DAT_W-1:0]   rdata_reg;               // Registered read data.

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire              bus_req   = WB_CYC_I & WB_STB_I & ~ack_reg;  // New request.
  wire              bus_wr    = bus_req & WB_WE_I;               // Write access.
  wire [7:0]        bus_idx   = WB_ADR_I[ADR_W-1:2];             // Word index.
  wire              hit_lth   = bus_idx == IDX_LOWER_THRESHOLD;  // Lower limit.
  wire              hit_uth   = bus_idx == IDX_UPPER_THRESHOLD;  // Upper limit.
  wire              hit_err   = bus_idx == IDX_COMPUTED_ERROR;   // Error.
  wire              hit_setpoint_value  = bus_idx == IDX_SETPOINT;         // Setpoint.
  wire              hit_flt   = bus_idx == IDX_FILTER_OUTPUT;    // Filter.
  wire              hit_acc   = bus_idx == IDX_ACCUMULATOR;      // Accumulator.
  wire              hit_ctl   = bus_idx == IDX_CONTROL;          // Control.
  wire              hit_flg   = bus_idx == IDX_FLAGS;            // Flags.
  wire              hit_ist   = bus_idx == IDX_IRQ_STATUS;       // Event status.
  wire              hit_imk   = bus_idx == IDX_IRQ_MASK;         // Event mask.

  // Control fields.
  wire [2:0]        threshold_mode_select = control_reg[CTL_TMD_LSB +: 3];
  wire [2:0]        error_select_a        = control_reg[CTL_ERROR_SELECT_A_LSB +: 3];
  wire [2:0]        filter_shift_select   = control_reg[CTL_SHIFT_LSB +: 3];
  wire [2:0]        compute_mode          = control_reg[CTL_MODE_LSB +: 3];

  // Accumulator view on the bus: bits 23:18 copy the sign bit, bits 31:24 read as zero.
  wire [23:0]       acc_view = {{6{accumulator_reg[17]}}, accumulator_reg};

  // Read multiplexer; unmapped addresses read as zero.
  wire [DAT_W-1:0]  rdata_next =
      hit_lth  ? {16'h0000, lower_threshold_reg}    :
      hit_uth  ? {16'h0000, upper_threshold_reg}    :
      hit_err  ? {16'h0000, computed_error_reg}     :
      hit_setpoint_value ? {16'h0000, threshold_setpoint_reg} :
      hit_flt  ? {16'h0000, filter_output_reg}      :
      hit_acc  ? {8'h00, acc_view}                  :
      hit_ctl  ? {16'h0000, control_reg}            :
      hit_flg  ? {30'h0, above_upper_flag_reg, below_lower_flag_reg} :
      hit_ist  ? {30'h0, irq_status_reg}            :
      hit_imk  ? {30'h0, irq_mask_reg}              :
                 32'h00000000;

  // --------------------------------------------------------------------------
  // Accumulator and filter arithmetic
  // --------------------------------------------------------------------------
  wire              acc_mode  = (compute_mode == MODE_ACCUM) |
                                (compute_mode == MODE_AVG) |
                                (compute_mode == MODE_BURST);
  wire              lpf_mode  = compute_mode == MODE_LPF;
  wire [17:0]       acc_sum   = accumulator_reg + sext18(CONV_RESULT);
  // Software write into the accumulator; byte lane 2 carries bits 17:16.
  wire [17:0]       acc_wr    = {WB_SEL_I[2] ? WB_DAT_I[17:16] : accumulator_reg[17:16],
                                 merge16(accumulator_reg[15:0], WB_DAT_I, WB_SEL_I)};
  // In the accumulating modes a new result wins over a simultaneous software write.
  wire [17:0]       acc_next  = (COMPUTE_DONE & acc_mode) ? acc_sum :
                                (bus_wr & hit_acc) ? acc_wr : accumulator_reg;
  wire [17:0]       acc_shift = $signed(acc_next) >>> filter_shift_select;
  // Low-pass step: move the filter by the shifted difference.
  wire [17:0]       lpf_diff  = sext18(CONV_RESULT) - sext18(filter_output_reg);
  wire [17:0]       lpf_step  = $signed(lpf_diff) >>> filter_shift_select;
  wire [17:0]       lpf_next  = sext18(filter_output_reg) + lpf_step;
  wire [15:0]       filter_next = lpf_mode ? lpf_next[15:0] :
                                  acc_mode ? acc_shift[15:0] : CONV_RESULT;

  // --------------------------------------------------------------------------
  // Error calculation and comparison
  // --------------------------------------------------------------------------
  // The setpoint feeds only the two selections that name it.
  wire [15:0]       err_next =
      (error_select_a == ERROR_SELECT_A_RES_SP)  ? result_reg - threshold_setpoint_reg :
      (error_select_a == ERROR_SELECT_A_RES_FLT) ? result_reg - filter_output_reg :
      (error_select_a == ERROR_SELECT_A_FLT_DRV) ? filter_output_reg - prev_filter_reg :
      (error_select_a == ERROR_SELECT_A_FLT_SP)  ? filter_output_reg - threshold_setpoint_reg :
                                         result_reg - prev_result_reg;
  wire              err_lt_low = $signed(computed_error_reg) <
                                 $signed(lower_threshold_reg);
  wire              err_gt_up  = $signed(computed_error_reg) >
                                 $signed(upper_threshold_reg);
  // Condition selected by the threshold mode.
  wire              tmd_hit =
      (threshold_mode_select == TMD_LT_LOW)  ?  err_lt_low :
      (threshold_mode_select == TMD_GE_LOW)  ? ~err_lt_low :
      (threshold_mode_select == TMD_INSIDE)  ? ~err_lt_low & ~err_gt_up :
      (threshold_mode_select == TMD_OUTSIDE) ?  err_lt_low |  err_gt_up :
      (threshold_mode_select == TMD_LE_UP)   ? ~err_gt_up :
      (threshold_mode_select == TMD_GT_UP)   ?  err_gt_up :
      (threshold_mode_select == TMD_ALWAYS);
  // New events this cycle; they win over a same-cycle clear.
  wire [IRQ_W-1:0]  irq_events = {cmp_pulse_reg, cmp_pulse_reg & tmd_hit};
  wire [IRQ_W-1:0]  irq_clear  = (bus_wr & hit_ist & WB_SEL_I[0]) ?
                                 WB_DAT_I[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0]  irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

  // --------------------------------------------------------------------------
  // Bus slave: one-cycle registered acknowledge, data registered with it
  // --------------------------------------------------------------------------
  // Every access, mapped or not, is answered one cycle after the request.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rdata_next : rdata_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Software-writable registers
  // --------------------------------------------------------------------------
  // Writes take effect on the edge at which the acknowledge rises.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lower_threshold_reg    <= RST_WORD16;
      upper_threshold_reg    <= RST_WORD16;
      threshold_setpoint_reg <= RST_WORD16;
      control_reg            <= RST_CTRL;
      irq_mask_reg           <= RST_IRQ;
    end else if (bus_wr) begin
      if (hit_lth) begin
        lower_threshold_reg <= merge16(lower_threshold_reg, WB_DAT_I, WB_SEL_I);
      end
      if (hit_uth) begin
        upper_threshold_reg <= merge16(upper_threshold_reg, WB_DAT_I, WB_SEL_I);
      end
      if (hit_setpoint_value) begin
        threshold_setpoint_reg <= merge16(threshold_setpoint_reg, WB_DAT_I, WB_SEL_I);
      end
      if (hit_ctl) begin
        control_reg <= merge16(control_reg, WB_DAT_I, WB_SEL_I);
      end
      if (hit_imk && WB_SEL_I[0]) begin
        irq_mask_reg <= WB_DAT_I[IRQ_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Computation pipeline
  // --------------------------------------------------------------------------
  // Stage 0 latches the result and updates accumulator and filter; stage 1
  // forms the error; stage 2 compares. Splitting the stages keeps the two
  // 16-bit subtract and compare chains off the same clock path.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      accumulator_reg   <= RST_ACC;
      filter_output_reg <= RST_WORD16;
      result_reg        <= RST_WORD16;
      prev_result_reg   <= RST_WORD16;
      prev_filter_reg   <= RST_WORD16;
      error_select_a_pulse_reg    <= 1'b0;
      cmp_pulse_reg     <= 1'b0;
    end else begin
      accumulator_reg <= acc_next;
      error_select_a_pulse_reg  <= COMPUTE_DONE;
      cmp_pulse_reg   <= error_select_a_pulse_reg;
      if (COMPUTE_DONE) begin
        filter_output_reg <= filter_next;
        result_reg        <= CONV_RESULT;
        prev_result_reg   <= result_reg;
        prev_filter_reg   <= filter_output_reg;
      end
    end
  end

  // Error register changes only from the pipeline; bus writes never reach it.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      computed_error_reg <= RST_WORD16;
    end else if (error_select_a_pulse_reg) begin
      computed_error_reg <= err_next;
    end
  end

  // Comparison flags follow each comparison stage.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      above_upper_flag_reg <= 1'b0;
      below_lower_flag_reg <= 1'b0;
    end else if (cmp_pulse_reg) begin
      above_upper_flag_reg <= err_gt_up;
      below_lower_flag_reg <= err_lt_low;
    end
  end

  // Sticky event bits, cleared by writing a one.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status_reg <= RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign WB_ACK_O    = ack_reg;
  assign WB_DAT_O    = rdata_reg;
  assign ABOVE_UPPER = above_upper_flag_reg;
  assign BELOW_LOWER = below_lower_flag_reg;
  assign IRQ         = |(irq_status_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  ack_one_cycle_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held longer than one cycle");

  ack_timely_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not acknowledged in one cycle");

  upper_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmp_pulse_reg |=> (ABOVE_UPPER == ($signed($past(computed_error_reg)) >
                                       $signed($past(upper_threshold_reg)))))
    else $error("upper flag disagrees with signed comparison");

  lower_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmp_pulse_reg |=> (BELOW_LOWER == ($signed($past(computed_error_reg)) <
                                       $signed($past(lower_threshold_reg)))))
    else $error("lower flag disagrees with signed comparison");

  irq_cause_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(irq_status_reg[IRQ_THR_BIT]) |->
      $past(cmp_pulse_reg) && $past(threshold_mode_select) != TMD_NEVER)
    else $error("threshold flag set without a selected condition");

  irq_always_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (cmp_pulse_reg && threshold_mode_select == TMD_ALWAYS) |=>
      irq_status_reg[IRQ_THR_BIT])
    else $error("always mode did not set the threshold flag");

  setpoint_err_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (error_select_a_pulse_reg && error_select_a == ERROR_SELECT_A_RES_SP) |=>
      computed_error_reg == 16'($past(result_reg) - $past(threshold_setpoint_reg)))
    else $error("setpoint error wrong");

  ro_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (bus_wr && hit_err && !error_select_a_pulse_reg) |=> $stable(computed_error_reg))
    else $error("write altered the error register");

  acc_sign_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (bus_req && !WB_WE_I && hit_acc) |=>
      WB_DAT_O[23:18] == {6{WB_DAT_O[17]}})
    else $error("accumulator upper bits not sign copies");

  filter_shift_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (COMPUTE_DONE && acc_mode && !lpf_mode) |=>
      filter_output_reg == 16'($signed(accumulator_reg) >>> $past(filter_shift_select)))
    else $error("filter is not the shifted accumulator");

  // Every comparison stage also records the completion event.
  done_event_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmp_pulse_reg |=> irq_status_reg[IRQ_DONE_BIT])
    else $error("completion event not recorded");

  // Never mode must leave a cleared threshold event cleared.
  never_mode_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (cmp_pulse_reg && threshold_mode_select == TMD_NEVER &&
     !irq_status_reg[IRQ_THR_BIT]) |=> !irq_status_reg[IRQ_THR_BIT])
    else $error("never mode raised the threshold event");

  // Writing a one clears the threshold event when no new event lands with it.
  status_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (bus_wr && hit_ist && WB_SEL_I[0] && WB_DAT_I[IRQ_THR_BIT] && !cmp_pulse_reg) |=>
      !irq_status_reg[IRQ_THR_BIT])
    else $error("threshold event survived its clear");

  // Selections without a setpoint must not see it; the derivative is one of them.
  deriv_err_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (error_select_a_pulse_reg && error_select_a == ERROR_SELECT_A_DERIV) |=>
      computed_error_reg == 16'($past(result_reg) - $past(prev_result_reg)))
    else $error("derivative error wrong");

  // Basic mode passes the new result straight to the filter register.
  basic_filter_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (COMPUTE_DONE && !acc_mode && !lpf_mode) |=>
      filter_output_reg == $past(CONV_RESULT))
    else $error("basic mode filter is not the result");

  // A bus write must never reach the filter register.
  filter_ro_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (bus_wr && hit_flt && !COMPUTE_DONE) |=> $stable(filter_output_reg))
    else $error("write altered the filter register");

endmodule

/* tb/act_regs_test.sv */
`timescale 1ns/1ps
module act_regs_test;
  import act_pkg::*;
  logic        clk = 0, reset_n = 0, we = 0, cyc = 0, stb = 0, done = 0;
  logic [9:0]  adr = '0;                 // Byte address.
  logic [31:0] wdat = '0, dato, rv;      // Bus data.
  logic [3:0]  sel = '0;                 // Byte lanes.
  logic [15:0] res = '0;                 // Conversion result.
  logic        ack, above, below, irq;   // Observed outputs.
  int          n_fail = 0, n_tests = 0;  // Mismatches and compares.
  localparam logic [9:0] A_LO = {IDX_LOWER_THRESHOLD, 2'b00}, A_UP = {IDX_UPPER_THRESHOLD, 2'b00};
  localparam logic [9:0] A_ER = {IDX_COMPUTED_ERROR, 2'b00}, A_SP = {IDX_SETPOINT, 2'b00};
  localparam logic [9:0] A_FL = {IDX_FILTER_OUTPUT, 2'b00}, A_AC = {IDX_ACCUMULATOR, 2'b00};
  localparam logic [9:0] A_CT = {IDX_CONTROL, 2'b00}, A_ST = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_MK = {IDX_IRQ_MASK, 2'b00};
  // Results giving errors above, inside and below the window; expected hit per mode.
  localparam logic [2:0][15:0] R_V = {16'hffe0, 16'h0005, 16'h0100};
  localparam logic [2:0][7:0]  HIT = {8'hb2, 8'hac, 8'hd4};
  act_regs i_dut (.CLK(clk), .RESET_N(reset_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dato),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .COMPUTE_DONE(done), .CONV_RESULT(res), .ABOVE_UPPER(above), .BELOW_LOWER(below), .IRQ(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // Bus and compare tasks.
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("Compares %0d, mismatches %0d.", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; ack is sampled at the edge, so the release follows it.
  task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rv = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0, 4'hf);
    chk(rv, exp);
  endtask
  // A result pulse, then three edges so flags and status have landed.
  task automatic cmp(input logic [15:0] v);
    @(posedge clk);
    done <= 1'b1;
    res <= v;
    @(posedge clk);
    done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rc(A_LO, 32'h0);
    rc(A_UP, 32'h0);
    rc(A_SP, 32'h0);
    wb(A_LO, 1'b1, 32'h000000f0, 4'h1);
    wb(A_LO, 1'b1, 32'h0000ff00, 4'h2);
    rc(A_LO, 32'h0000fff0);
    wb(A_UP, 1'b1, 32'h00000010, 4'h3);
    rc(A_UP, 32'h00000010);
    wb(A_SP, 1'b1, 32'h00000005, 4'h3);
    wb(A_CT, 1'b1, 32'h00000024, 4'h3);
    wb(A_MK, 1'b1, 32'h00000001, 4'h1);
    cmp(16'h0100);
    rc(A_ER, 32'h000000fb);
    chk({30'h0, above, below}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rc(A_ST, 32'h3);
    wb(A_ER, 1'b1, 32'h00001234, 4'hf);
    rc(A_ER, 32'h000000fb);
    rc(10'h3fc, 32'h0);
    wb(A_ST, 1'b1, 32'h1, 4'h1);
    chk({31'h0, irq}, 32'h0);
    cmp(16'hffe0);
    rc(A_ER, 32'h0000ffdb);
    chk({30'h0, above, below}, 32'h1);
    wb(A_CT, 1'b1, 32'h00000020, 4'h3);
    wb(A_ST, 1'b1, 32'h3, 4'h1);
    cmp(16'h0100);
    chk({29'h0, above, below, irq}, 32'h4);
    // Every threshold mode against an error above, inside and below the window.
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 8; m++) begin
        wb(A_CT, 1'b1, 32'h00000020 + 32'(m), 4'h3);
        wb(A_ST, 1'b1, 32'h3, 4'h1);
        cmp(R_V[r]);
        rc(A_ST, {30'h0, 1'b1, HIT[r][m]});
      end
    end
    wb(A_CT, 1'b1, 32'h00001120, 4'h3);
    wb(A_AC, 1'b1, 32'h0, 4'h7);
    cmp(16'h0100);
    rc(A_FL, 32'h00000080);
    cmp(16'hfe00);
    rc(A_AC, 32'h00ffff00);
    rc(A_FL, 32'h0000ff80);
    // Low-pass mode with the plain derivative, so the setpoint must not matter.
    wb(A_CT, 1'b1, 32'h00004100, 4'h3);
    cmp(16'h0100);
    rc(A_FL, 32'h00000040);
    rc(A_ER, 32'h00000300);
    wb(A_FL, 1'b1, 32'h00001234, 4'hf);
    rc(A_FL, 32'h00000040);
    close_out();
  end
endmodule
